// ==== sflash_defs.svh ====
`ifndef SFLASH_DEFS_SVH
`define SFLASH_DEFS_SVH

// instruction codes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B

// status byte bit positions
`define SB_PROGRESS 0
`define SB_WR_EN 1
`define ST_BP_LO 2
`define ST_BP_HI 4
`define SB_WR_LOCK 7

// serial framing
`define BITS_PER_BYTE 3'h7
`define ADDR_BYTES 2'h2
`define FRAME_BITS_ONE 5'h08
`define FRAME_BITS_TWO 5'h10
`define FRAME_BITS_MAX 5'h1F

// timing
`define CLK_PERIOD_NS 8
`define T_STATUS_WRITE_NS 5000

// reset values
`define BP_RESET 3'h0
`define BYTE_ZERO 8'h00

`endif

// ==== sflash_pkg.sv ====
`default_nettype none
`include "sflash_defs.svh"

package sflash_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_ADDR = 3'h3,
    ST_DUMMY = 3'h2,
    ST_RD_OUT = 3'h6,
    ST_STAT_OUT = 3'h7,
    ST_WR_DATA = 3'h5,
    ST_IGNORE = 3'h4
  } spi_state_e;

  typedef struct packed {
    logic wr_lock;
    logic [1:0] zero;
    logic [2:0] bp;
    logic wr_en;
    logic in_progress;
  } status_s;

endpackage
`default_nettype wire

// ==== sflash_core.sv ====
// Summary of operation
// R01 - status write only accepted when write enable latch was set earlier
// R02 - host sends status write opcode then one data byte after chip select falls
// R03 - status write never changes bits 6, 5, 1 and 0
// R04 - bits 6 and 5 always read as zero
// R05 - status write discarded unless chip select rises right after the data byte
// R06 - accepted status write starts timed cycle; progress flag high during it
// R07 - status reads still answered while the write cycle runs
// R08 - write enable latch cleared when the write cycle completes
// R09 - accepted status write updates block protect bits and write disable bit
// R10 - write disable bit low: writes allowed with latch set, any protect pin level
// R11 - write disable bit high, protect pin high: writes allowed with latch set
// R12 - write disable bit high, protect pin low: hardware protected, writes rejected
// R13 - hardware protection entered by whichever of bit or pin comes last
// R14 - hardware protection left only by raising the protect pin
// R15 - protected region refused program and erase in both protection modes
// R16 - read takes 24-bit address on rising edges, data out on falling edges
// R17 - reads start anywhere; address increments after every data byte
// R18 - address wraps to zero after the highest array location
// R19 - chip select rising during output stops driving and ends the read
// R20 - reads rejected while any write, program or erase cycle runs
// R21 - fast read waits one dummy byte before data output
// R22 - fast read ignores the four upper address bits
// R23 - everything travels most significant bit first
// R24 - progress flag is one during any write, program or erase cycle
// R25 - rejected status write leaves status and latch unchanged
`timescale 1ns/1ps
`default_nettype none
`include "sflash_defs.svh"

module sflash_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

module sflash_core
  import sflash_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int FIFO_DEPTH = 8,
  parameter int T_W_NS = `T_STATUS_WRITE_NS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  input wire logic wp_n,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic array_rd_en,
  output logic [ADDR_W-1:0] array_rd_addr,
  input wire logic [7:0] array_rd_data,
  input wire logic ext_cycle_busy,
  output status_s status,
  output logic hardware_protected_mode,
  output logic software_protected_mode
);
  localparam int WCYC = (T_W_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int WCW = $clog2(WCYC + 1);
  localparam logic [WCW-1:0] WCYC_LAST = WCW'(WCYC - 1);

  logic rst_s1_q;
  logic rst_n_q;
  logic [2:0] cs_q;
  logic [2:0] sck_q;
  logic [1:0] mosi_q;
  logic [1:0] wp_q;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic mosi_in;
  logic wp_in;

  spi_state_e state_q;
  logic [2:0] bit_q;
  logic [1:0] abyte_q;
  logic [4:0] frame_bits_q;
  logic [7:0] shift_q;
  logic [7:0] cmd_q;
  logic [7:0] wdata_q;
  logic [23:0] addr_q;
  logic fast_q;
  logic [7:0] byte_in;
  logic byte_done;
  logic fetch_start;

  logic wr_lock_q;
  logic [2:0] bp_q;
  logic wr_en_q;
  logic wr_busy_q;
  logic [WCW-1:0] wcnt_q;
  logic busy;
  logic hw_lock;
  status_s stat_now;

  logic [2:0] out_cnt_q;
  logic [6:0] out_sh_q;
  logic [7:0] out_byte;
  logic pop;

  logic fetch_on_q;
  logic [ADDR_W-1:0] fetch_addr_q;
  logic rd_ret_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  // reset release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // pin synchronisers; third stage only for edge finding
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cs_q <= 3'h7;
      sck_q <= 3'h0;
      mosi_q <= 2'h0;
      wp_q <= 2'h3;
    end else begin
      cs_q <= {cs_q[1:0], spi_cs_n};
      sck_q <= {sck_q[1:0], spi_sck};
      mosi_q <= {mosi_q[0], spi_mosi};
      wp_q <= {wp_q[0], wp_n};
    end
  end

  assign cs_rise = cs_q[1] && !cs_q[2];
  assign cs_fall = !cs_q[1] && cs_q[2];
  assign sck_rise = sck_q[1] && !sck_q[2] && !cs_q[1];
  assign sck_fall = !sck_q[1] && sck_q[2] && !cs_q[1];
  assign mosi_in = mosi_q[1];
  assign wp_in = wp_q[1];

  assign byte_in = {shift_q[6:0], mosi_in}; // [R23]
  assign byte_done = sck_rise && (bit_q == `BITS_PER_BYTE);
  assign fetch_start = byte_done && (state_q == ST_ADDR) && (abyte_q == `ADDR_BYTES);

  assign busy = wr_busy_q || ext_cycle_busy; // [R24]
  assign hw_lock = wr_lock_q && !wp_in; // [R12] [R13] [R14]

  always_comb begin
    stat_now = '0;
    stat_now.wr_lock = wr_lock_q;
    stat_now.zero = 2'h0; // [R04]
    stat_now.bp = bp_q;
    stat_now.wr_en = wr_en_q;
    stat_now.in_progress = busy; // [R24]
  end

  // serial input framing
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      bit_q <= 3'h0;
      abyte_q <= 2'h0;
      frame_bits_q <= 5'h00;
      shift_q <= `BYTE_ZERO;
      cmd_q <= `BYTE_ZERO;
      wdata_q <= `BYTE_ZERO;
      addr_q <= 24'h000000;
      fast_q <= 1'b0;
    end else if (cs_q[1]) begin
      state_q <= ST_IDLE;
    end else if (cs_fall) begin
      state_q <= ST_CMD;
      bit_q <= 3'h0;
      abyte_q <= 2'h0;
      frame_bits_q <= 5'h00;
    end else if (sck_rise) begin
      shift_q <= byte_in;
      bit_q <= bit_q + 3'h1;
      if (frame_bits_q != `FRAME_BITS_MAX) begin
        frame_bits_q <= frame_bits_q + 5'h01;
      end
      if (state_q == ST_ADDR) begin
        addr_q <= {addr_q[22:0], mosi_in}; // [R16] [R23]
      end
      if (byte_done) begin
        unique case (state_q)
          ST_CMD: begin
            cmd_q <= byte_in;
            unique case (byte_in)
              `OP_STATUS_READ: state_q <= ST_STAT_OUT; // [R07]
              `OP_STATUS_WRITE: state_q <= ST_WR_DATA; // [R02]
              `OP_READ, `OP_FAST_READ: begin
                fast_q <= (byte_in == `OP_FAST_READ);
                state_q <= busy ? ST_IGNORE : ST_ADDR; // [R20]
              end
              default: state_q <= ST_IGNORE;
            endcase
          end
          ST_ADDR: begin
            abyte_q <= abyte_q + 2'h1;
            if (abyte_q == `ADDR_BYTES) begin
              state_q <= fast_q ? ST_DUMMY : ST_RD_OUT; // [R21]
            end
          end
          ST_DUMMY: state_q <= ST_RD_OUT; // [R21]
          ST_WR_DATA: begin
            wdata_q <= byte_in;
            state_q <= ST_IGNORE;
          end
          ST_IDLE, ST_RD_OUT, ST_STAT_OUT, ST_IGNORE: state_q <= state_q;
        endcase
      end
    end
  end

  // status register, latch and self-timed write cycle
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_lock_q <= 1'b0;
      bp_q <= `BP_RESET;
      wr_en_q <= 1'b0;
      wr_busy_q <= 1'b0;
      wcnt_q <= '0;
    end else begin
      if (wr_busy_q) begin
        if (wcnt_q == '0) begin
          wr_busy_q <= 1'b0; // [R06]
          wr_en_q <= 1'b0; // [R08]
        end else begin
          wcnt_q <= wcnt_q - 1'b1;
        end
      end else if (cs_rise && !ext_cycle_busy) begin
        // rejected frames fall through and touch nothing
        if (cmd_q == `OP_WRITE_ENABLE && frame_bits_q == `FRAME_BITS_ONE) begin
          wr_en_q <= 1'b1;
        end else if (cmd_q == `OP_WRITE_DISABLE && frame_bits_q == `FRAME_BITS_ONE) begin
          wr_en_q <= 1'b0;
        end else if (cmd_q == `OP_STATUS_WRITE && frame_bits_q == `FRAME_BITS_TWO // [R05] [R25]
                     && wr_en_q && !hw_lock) begin // [R01] [R10] [R11] [R12]
          wr_lock_q <= wdata_q[`SB_WR_LOCK]; // [R09]
          bp_q <= wdata_q[`ST_BP_HI:`ST_BP_LO]; // [R09] [R03]
          wr_busy_q <= 1'b1; // [R06]
          wcnt_q <= WCYC_LAST;
        end
      end
    end
  end

  // exported protection state for the program and erase logic
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status <= '0;
      hardware_protected_mode <= 1'b0;
      software_protected_mode <= 1'b1;
    end else begin
      status <= stat_now; // [R15]
      hardware_protected_mode <= hw_lock;
      software_protected_mode <= !hw_lock;
    end
  end

  // serial output on falling clock edges
  assign pop = sck_fall && (state_q == ST_RD_OUT) && (out_cnt_q == 3'h0);
  // empty fifo shifts zeros; only reached if sck falls before the first array read returns
  assign out_byte = (state_q == ST_RD_OUT) ? (fifo_out_valid ? fifo_out_data : `BYTE_ZERO) : stat_now;

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
      out_cnt_q <= 3'h0;
      out_sh_q <= 7'h00;
    end else if (cs_q[1]) begin
      spi_miso_oe <= 1'b0; // [R19]
      out_cnt_q <= 3'h0;
    end else if (sck_fall && (state_q == ST_RD_OUT || state_q == ST_STAT_OUT)) begin
      spi_miso_oe <= 1'b1; // [R16]
      out_cnt_q <= out_cnt_q + 3'h1;
      if (out_cnt_q == 3'h0) begin
        spi_miso <= out_byte[7]; // [R23]
        out_sh_q <= out_byte[6:0];
      end else begin
        spi_miso <= out_sh_q[6];
        out_sh_q <= {out_sh_q[5:0], 1'b0};
      end
    end
  end

  // array prefetch; one read in flight keeps fifo room honest
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fetch_on_q <= 1'b0;
      fetch_addr_q <= '0;
      array_rd_en <= 1'b0;
      array_rd_addr <= '0;
      rd_ret_q <= 1'b0;
    end else if (fetch_start) begin
      fetch_on_q <= 1'b1;
      fetch_addr_q <= byte_in[0] ? {addr_q[ADDR_W-2:0], 1'b1} : {addr_q[ADDR_W-2:0], 1'b0}; // [R22]
      array_rd_en <= 1'b0;
      rd_ret_q <= 1'b0;
    end else if (cs_q[1]) begin
      fetch_on_q <= 1'b0; // [R19]
      array_rd_en <= 1'b0;
      rd_ret_q <= 1'b0;
    end else begin
      rd_ret_q <= array_rd_en;
      array_rd_en <= 1'b0;
      if (fetch_on_q && fifo_in_ready && !array_rd_en && !rd_ret_q) begin
        array_rd_en <= 1'b1;
        array_rd_addr <= fetch_addr_q; // [R17]
        fetch_addr_q <= fetch_addr_q + 1'b1; // [R17] [R18]
      end
    end
  end

  sflash_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .flush(fetch_start || cs_q[1]),
    .in_valid(rd_ret_q && fetch_on_q),
    .in_ready(fifo_in_ready),
    .in_data(array_rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );
endmodule
`default_nettype wire

// ==== sflash_core_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module sflash_core_properties
  import sflash_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic spi_cs_n,
  input wire logic wp_n,
  input wire logic ext_cycle_busy,
  input wire logic spi_miso_oe,
  input wire logic array_rd_en,
  input wire logic [ADDR_W-1:0] array_rd_addr,
  input wire status_s status,
  input wire logic hardware_protected_mode
);
  logic first_q;
  logic [ADDR_W-1:0] last_q;
  // the first fetch of a frame may start anywhere
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) first_q <= 1'b1;
    else if (spi_cs_n) first_q <= 1'b1;
    else if (array_rd_en) first_q <= 1'b0;
  end
  always_ff @(posedge clk_sys) begin
    if (array_rd_en) last_q <= array_rd_addr;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_zero_bits; status.zero == 2'h0; endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("reserved status bits not zero");
  property p_hw_lock; hardware_protected_mode |-> status.wr_lock; endproperty
  a_hw_lock: assert property (p_hw_lock)
    else $error("protected mode without disable bit");
  property p_hw_exit; wp_n [*6] |-> !hardware_protected_mode; endproperty
  a_hw_exit: assert property (p_hw_exit)
    else $error("protected mode with pin high");
  property p_hw_enter; (!wp_n && status.wr_lock) [*6] |-> hardware_protected_mode; endproperty
  a_hw_enter: assert property (p_hw_enter)
    else $error("protected mode not entered");
  // status lags the busy input by one register, hence depth two
  property p_latch_clear; $fell(status.in_progress) && !$past(ext_cycle_busy, 2) |-> !status.wr_en; endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("latch still set after cycle");
  property p_commit; $changed({status.wr_lock, status.bp}) |-> ##[0:1] status.in_progress; endproperty
  a_commit: assert property (p_commit)
    else $error("protect bits changed outside a cycle");
  property p_busy_flag; ext_cycle_busy |-> ##[0:2] status.in_progress; endproperty
  a_busy_flag: assert property (p_busy_flag)
    else $error("progress flag low while busy");
  property p_no_fetch; status.in_progress && $past(status.in_progress) |-> !array_rd_en; endproperty
  a_no_fetch: assert property (p_no_fetch)
    else $error("array fetch during write cycle");
  property p_oe_release; spi_cs_n [*8] |-> !spi_miso_oe; endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("output driven while deselected");
  property p_addr_seq; array_rd_en && !first_q |-> array_rd_addr == last_q + 1'b1; endproperty
  a_addr_seq: assert property (p_addr_seq)
    else $error("read address not sequential");
endmodule
bind sflash_core sflash_core_properties #(.ADDR_W(ADDR_W)) u_sflash_core_properties (
  .clk_sys(clk_sys), .resetn(resetn), .spi_cs_n(spi_cs_n), .wp_n(wp_n),
  .ext_cycle_busy(ext_cycle_busy), .spi_miso_oe(spi_miso_oe), .array_rd_en(array_rd_en),
  .array_rd_addr(array_rd_addr), .status(status), .hardware_protected_mode(hardware_protected_mode));
`default_nettype wire

// ==== sflash_array_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sflash_array_model (
  input wire logic clk_sys,
  input wire logic rd_en,
  input wire logic [19:0] rd_addr,
  output logic [7:0] rd_data
);
  // valid only the cycle after a request; toggles otherwise so stale use shows
  always_ff @(posedge clk_sys) begin
    if (rd_en) rd_data <= rd_addr[7:0] ^ rd_addr[19:12];
    else rd_data <= ~rd_data;
  end
endmodule
`default_nettype wire

// ==== sflash_core_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module sflash_core_test;
  import sflash_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic spi_cs_n = 1'b1;
  logic spi_sck = 1'b0;
  logic spi_mosi = 1'b0;
  logic wp_n = 1'b1;
  logic ext_cycle_busy = 1'b0;
  logic spi_miso, spi_miso_oe, array_rd_en, hw_mode, sw_mode;
  logic [19:0] array_rd_addr;
  logic [7:0] array_rd_data, rx;
  status_s status;
  int bad_count = 0;
  int total_checks = 0;
  always #4 clk_sys = ~clk_sys;
  sflash_core #(.T_W_NS(8000)) u_sflash_core (.clk_sys(clk_sys), .resetn(resetn),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .wp_n(wp_n),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .array_rd_en(array_rd_en),
    .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data),
    .ext_cycle_busy(ext_cycle_busy), .status(status),
    .hardware_protected_mode(hw_mode), .software_protected_mode(sw_mode));
  sflash_array_model u_sflash_array_model (.clk_sys(clk_sys), .rd_en(array_rd_en),
    .rd_addr(array_rd_addr), .rd_data(array_rd_data));
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task clks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // mode 0, msb first; miso sampled at the rising sck edge
  task xb(input logic [7:0] o, input int n);
    for (int b = 7; b > 7 - n; b--) begin
      spi_mosi = o[b];
      clks(5);
      spi_sck = 1'b1;
      rx[b] = spi_miso;
      clks(5);
      spi_sck = 1'b0;
    end
  endtask
  task cs_lo();
    spi_cs_n = 1'b0;
    clks(5);
  endtask
  task cs_hi();
    clks(5);
    spi_cs_n = 1'b1;
    clks(8);
  endtask
  task cmd(input logic [7:0] o);
    cs_lo();
    xb(o, 8);
    cs_hi();
  endtask
  task stat_wr(input logic [7:0] d);
    cs_lo();
    xb(8'h01, 8);
    xb(d, 8);
    cs_hi();
  endtask
  task rdsr(input logic [7:0] e);
    cs_lo();
    xb(8'h05, 8);
    xb(8'h00, 8);
    cs_hi();
    chk(rx, e);
  endtask
  task wait_idle();
    for (int i = 0; i < 2000 && status.in_progress !== 1'b0; i++) clks(1);
    if (status.in_progress !== 1'b0) begin
      bad_count++;
      $display("wrong value at %0t: write cycle never ended", $time);
      summarize();
    end
  endtask
  task rd_hdr(input logic [7:0] op, input logic [23:0] a);
    cs_lo();
    xb(op, 8);
    xb(a[23:16], 8);
    xb(a[15:8], 8);
    xb(a[7:0], 8);
    if (op == 8'h0B) xb(8'h00, 8);
  endtask
  task rd(input logic [7:0] op, input logic [23:0] a, input int n, input logic [19:0] e);
    rd_hdr(op, a);
    for (int k = 0; k < n; k++) begin
      xb(8'h00, 8);
      chk(rx, e[7:0] ^ e[19:12]);
      e = e + 20'h1;
    end
    cs_hi();
  endtask
  initial begin
    clks(12);
    resetn = 1'b1;
    clks(6);
    rdsr(8'h00);
    stat_wr(8'h9C);
    rdsr(8'h00);
    cmd(8'h06);
    rdsr(8'h02);
    cmd(8'h04);
    stat_wr(8'hFF);
    rdsr(8'h00);
    cmd(8'h06);
    stat_wr(8'hFF);
    rdsr(8'h9F);
    wait_idle();
    rdsr(8'h9C);
    wp_n = 1'b0;
    clks(6);
    chk({7'h00, hw_mode}, 8'h01);
    chk({7'h00, sw_mode}, 8'h00);
    chk({5'h00, status.bp}, 8'h07);
    cmd(8'h06);
    stat_wr(8'h00);
    wait_idle();
    rdsr(8'h9E);
    wp_n = 1'b1;
    clks(6);
    chk({7'h00, hw_mode}, 8'h00);
    chk({7'h00, sw_mode}, 8'h01);
    stat_wr(8'h00);
    wait_idle();
    rdsr(8'h00);
    wp_n = 1'b0;
    cmd(8'h06);
    stat_wr(8'h80);
    wait_idle();
    chk({7'h00, hw_mode}, 8'h01);
    rdsr(8'h80);
    wp_n = 1'b1;
    cmd(8'h06);
    cmd(8'h01);
    cs_lo();
    xb(8'h01, 8);
    xb(8'h00, 8);
    xb(8'h00, 1);
    cs_hi();
    rdsr(8'h82);
    rd(8'h03, 24'h0FFFFE, 12, 20'hFFFFE);
    rd(8'h0B, 24'hAFFFFE, 4, 20'hFFFFE);
    rd_hdr(8'h03, 24'h012345);
    xb(8'h00, 3);
    chk({7'h00, spi_miso_oe}, 8'h01);
    cs_hi();
    chk({7'h00, spi_miso_oe}, 8'h00);
    stat_wr(8'h00);
    rd_hdr(8'h03, 24'h000000);
    xb(8'h00, 8);
    chk({7'h00, spi_miso_oe}, 8'h00);
    cs_hi();
    wait_idle();
    rdsr(8'h00);
    ext_cycle_busy = 1'b1;
    clks(3);
    chk(status, 8'h01);
    ext_cycle_busy = 1'b0;
    clks(4);
    summarize();
  end
endmodule
`default_nettype wire
